// *** iwc_idle_unit.sv ***
// Idle command decoder and wait-for-event sequencer.
// Assumes a byte stream from the host link framer and wake pins straight from the package.
// Summary of operation
// - Command byte 07 starts an idle request that takes the unit into wait-for-event mode.
// - The length byte must be 0E, followed by the fourteen parameter bytes in fixed order.
// - Wake-source bits 0x01, 0x02, 0x08, 0x10 allow timer, tag, interrupt-pin and select-pin wakes.
// - The two entry control bytes are held and driven out while entering wait mode.
// - The two wake control bytes are held and driven out for the resources kept awake.
// - The two leave control bytes default to low 0x18, high 0x00 and are driven out on return to ready.
// - After a wake, oscillator then converter settle for their byte count of slow periods each.
// - The low comparator byte is the lower tag threshold; the host zeroes it during calibration.
// - The high comparator byte is the upper tag threshold, swept during calibration.
// - The swing-count byte, default 0x3F, limits carrier swings per detection attempt.
// - The trial-limit byte caps detection attempts; the host keeps it inside 0x00..0x1F.
// - Timeout fires after 256 slow periods times (period + 2) times (trial limit + 1).
// - The period byte sets the spacing of detection bursts and scales the timeout.
// - Only on leaving wait mode the reply 00, 01, wake cause is sent.
// - A bad length gets the reply 82, 00 and the unit stays out of wait mode.
// - Wake-source bits 7:6 pick the slow oscillator rate, 00 for 32 kHz up to 11 for 4 kHz.
`timescale 1ns/1ps
module iwc_idle_unit
  import iwc_pkg::*;
#(
  parameter int unsigned CYC_32K = SLOW_CYC_32K,
  parameter int unsigned CYC_16K = SLOW_CYC_16K,
  parameter int unsigned CYC_8K  = SLOW_CYC_8K,
  parameter int unsigned CYC_4K  = SLOW_CYC_4K
) (
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  input  wire logic       cmd_valid_i,
  input  wire logic [7:0] cmd_byte_i,
  input  wire logic       cmd_last_i,
  input  wire logic       rsp_ready_i,
  output logic            rsp_valid_o,
  output logic [7:0]      rsp_byte_o,
  output logic            rsp_last_o,
  input  wire logic       irq_in_pin_i,
  input  wire logic       slave_sel_pin_i,
  input  wire logic       tag_detect_i,
  output logic            wait_mode_o,
  output logic            detect_burst_o,
  output logic            fast_osc_settle_o,
  output logic            converter_settle_o,
  output logic [7:0]      entry_control_low_o,
  output logic [7:0]      entry_control_high_o,
  output logic [7:0]      wake_control_low_o,
  output logic [7:0]      wake_control_high_o,
  output logic [7:0]      leave_control_low_o,
  output logic [7:0]      leave_control_high_o,
  output logic [7:0]      cmp_low_o,
  output logic [7:0]      cmp_high_o,
  output logic [7:0]      swing_count_o
);
  iwc_state_e  state_r;
  iwc_state_e  state_nxt;
  logic [7:0]  par_r [NPAR];
  logic [3:0]  idx_r;
  logic        err_r;
  logic        err_nxt;
  logic [7:0]  cause_r;
  logic [16:0] frame_cnt_r;
  logic [7:0]  trial_cnt_r;
  logic [7:0]  set_cnt_r;
  logic [1:0]  rsp_idx_r;
  logic        rsp_valid_r;
  logic [7:0]  rsp_byte_r;
  logic        rsp_last_r;
  logic        wait_mode_r;
  logic        burst_r;
  logic        osc_set_r;
  logic        dac_set_r;
  logic [1:0]  pin_s1_r;
  logic [1:0]  pin_s2_r;
  logic [1:0]  pin_s3_r;
  logic [1:0]  pin_lvl_r;
  logic [1:0]  pin_lvl_nxt;
  logic [1:0]  pin_fall;

  iwc_tick_if tk ();

  iwc_slow_tick #(
    .CYC_32K (CYC_32K),
    .CYC_16K (CYC_16K),
    .CYC_8K  (CYC_8K),
    .CYC_4K  (CYC_4K)
  ) u_tick (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .tk     (tk)
  );

  function automatic logic [7:0] rsp_pick(input logic err, input logic [1:0] idx, input logic [7:0] cause);
    if (err) begin
      rsp_pick = (idx == 2'h0) ? RSP_ERR : RSP_ERR_LEN;
    end else begin
      rsp_pick = (idx == 2'h0) ? RSP_OK : (idx == 2'h1) ? RSP_OK_LEN : cause;
    end
  endfunction

  // Pin wake inputs: three stages, a level counts once stages two and three agree
  wire [1:0] pin_raw = {slave_sel_pin_i, irq_in_pin_i};
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_pin
      assign pin_lvl_nxt[g] = (pin_s2_r[g] == pin_s3_r[g]) ? pin_s3_r[g] : pin_lvl_r[g];
      assign pin_fall[g]    = pin_lvl_r[g] && !pin_lvl_nxt[g];
      always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
          pin_s1_r[g]  <= 1'b1;
          pin_s2_r[g]  <= 1'b1;
          pin_s3_r[g]  <= 1'b1;
          pin_lvl_r[g] <= 1'b1;
        end else begin
          pin_s1_r[g]  <= pin_raw[g];
          pin_s2_r[g]  <= pin_s1_r[g];
          pin_s3_r[g]  <= pin_s2_r[g];
          pin_lvl_r[g] <= pin_lvl_nxt[g];
        end
      end
    end
  endgenerate

  wire        in_wfe      = (state_r == S_WFE);
  wire        byte_in     = cmd_valid_i && (state_r != S_RSP);
  wire        rsp_done    = rsp_valid_r && rsp_ready_i && rsp_last_r;
  wire [16:0] frame_last  = {9'(par_r[P_PER]) + 9'h002, 8'h00} - 17'h00001;
  wire        frame_end   = in_wfe && tk.tick && (frame_cnt_r == frame_last);
  wire        timeout     = frame_end && (trial_cnt_r == par_r[P_TRIAL]);
  wire [7:0]  wake_raw    = {3'h0, pin_fall[1], pin_fall[0], 1'b0, tag_detect_i, timeout};
  wire [7:0]  wake_vec    = in_wfe ? (wake_raw & par_r[P_SRC] & SRC_MASK) : 8'h00;
  wire        osc_done    = (state_r == S_OSC) && (set_cnt_r == par_r[P_OSC]);
  wire        dac_done    = (state_r == S_DAC) && (set_cnt_r == par_r[P_DAC]);
  wire        par_full    = (idx_r == 4'(NPAR - 1));

  assign tk.run  = in_wfe || (state_r == S_OSC) || (state_r == S_DAC);
  assign tk.rate = par_r[P_SRC][RATE_LSB +: 2];

  always_comb begin
    state_nxt = state_r;
    err_nxt   = err_r;
    case (state_r)
      S_IDLE: if (byte_in) begin
        if (cmd_byte_i == CMD_IDLE) begin
          err_nxt   = 1'b1;
          state_nxt = cmd_last_i ? S_RSP : S_LEN;
        end else if (!cmd_last_i) begin
          err_nxt   = 1'b0;
          state_nxt = S_DRAIN;
        end
      end
      S_LEN: if (byte_in) begin
        if (cmd_last_i) begin
          state_nxt = S_RSP;
        end else begin
          state_nxt = (cmd_byte_i == LEN_IDLE) ? S_PAR : S_DRAIN;
        end
      end
      S_PAR: if (byte_in) begin
        if (par_full && cmd_last_i) begin
          err_nxt   = 1'b0;
          state_nxt = S_WFE;
        end else if (cmd_last_i) begin
          state_nxt = S_RSP;
        end else if (par_full) begin
          state_nxt = S_DRAIN;
        end
      end
      S_DRAIN: if (byte_in && cmd_last_i) begin
        state_nxt = err_r ? S_RSP : S_IDLE;
      end
      S_WFE:   if (wake_vec != 8'h00) state_nxt = S_OSC;
      S_OSC:   if (osc_done) state_nxt = S_DAC;
      S_DAC:   if (dac_done) state_nxt = S_RSP;
      S_RSP:   if (rsp_done) state_nxt = S_IDLE;
      default: state_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      state_r <= S_IDLE;
      err_r   <= 1'b0;
      idx_r   <= '0;
    end else begin
      state_r <= state_nxt;
      err_r   <= err_nxt;
      idx_r   <= (state_r == S_PAR && byte_in) ? idx_r + 4'h1 : (state_r == S_PAR ? idx_r : 4'h0);
    end
  end

  // Parameters are written in place; a too-long frame leaves them changed but never enters wait mode
  generate
    for (g = 0; g < NPAR; g++) begin : g_par
      always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
          par_r[g] <= RST_PAR[g];
        end else if (state_r == S_PAR && byte_in && idx_r == 4'(g)) begin
          par_r[g] <= cmd_byte_i;
        end
      end
    end
  endgenerate

  // Frame and settle counters in slow periods, trial counter in frames
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      frame_cnt_r <= '0;
      trial_cnt_r <= '0;
      set_cnt_r   <= '0;
      cause_r     <= '0;
      burst_r     <= 1'b0;
    end else begin
      frame_cnt_r <= !in_wfe ? 17'h00000 : frame_end ? 17'h00000 : frame_cnt_r + {16'h0000, tk.tick};
      trial_cnt_r <= !in_wfe ? 8'h00 : timeout ? 8'h00 : trial_cnt_r + {7'h00, frame_end};
      set_cnt_r   <= (osc_done || !tk.run || in_wfe) ? 8'h00 : set_cnt_r + {7'h00, tk.tick};
      burst_r     <= frame_end && par_r[P_SRC][SRC_TAG];
      if (in_wfe && wake_vec != 8'h00) begin
        cause_r <= wake_vec;
      end
    end
  end

  // Reply path: first byte loads on entry, each accepted byte but the last advances; accepting the last ends the reply
  wire rsp_enter = (state_nxt == S_RSP) && (state_r != S_RSP);
  wire rsp_step  = rsp_valid_r && rsp_ready_i && !rsp_last_r;
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      rsp_valid_r <= 1'b0;
      rsp_byte_r  <= 8'h00;
      rsp_last_r  <= 1'b0;
      rsp_idx_r   <= 2'h0;
    end else if (rsp_enter) begin
      rsp_valid_r <= 1'b1;
      rsp_byte_r  <= rsp_pick(err_nxt, 2'h0, cause_r);
      rsp_last_r  <= 1'b0;
      rsp_idx_r   <= 2'h0;
    end else if (rsp_step) begin
      rsp_byte_r  <= rsp_pick(err_r, rsp_idx_r + 2'h1, cause_r);
      rsp_last_r  <= (rsp_idx_r + 2'h1) == (err_r ? RSP_ERR_LAST : RSP_OK_LAST);
      rsp_idx_r   <= rsp_idx_r + 2'h1;
    end else if (rsp_done) begin
      rsp_valid_r <= 1'b0;
      rsp_last_r  <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      wait_mode_r <= 1'b0;
      osc_set_r   <= 1'b0;
      dac_set_r   <= 1'b0;
    end else begin
      wait_mode_r <= (state_nxt == S_WFE);
      // A zero settle byte means no wait, so the flag stays low for the pass-through cycle
      osc_set_r   <= (state_nxt == S_OSC) && (par_r[P_OSC] != 8'h00);
      dac_set_r   <= (state_nxt == S_DAC) && (par_r[P_DAC] != 8'h00);
    end
  end

  assign rsp_valid_o          = rsp_valid_r;
  assign rsp_byte_o           = rsp_byte_r;
  assign rsp_last_o           = rsp_last_r;
  assign wait_mode_o          = wait_mode_r;
  assign detect_burst_o       = burst_r;
  assign fast_osc_settle_o    = osc_set_r;
  assign converter_settle_o   = dac_set_r;
  assign entry_control_low_o  = par_r[P_ENT_L];
  assign entry_control_high_o = par_r[P_ENT_H];
  assign wake_control_low_o   = par_r[P_WAK_L];
  assign wake_control_high_o  = par_r[P_WAK_H];
  assign leave_control_low_o  = par_r[P_LEV_L];
  assign leave_control_high_o = par_r[P_LEV_H];
  assign cmp_low_o            = par_r[P_CMP_L];
  assign cmp_high_o           = par_r[P_CMP_H];
  assign swing_count_o        = par_r[P_SWING];

  // Checking helpers: slow ticks since wait mode began
  logic [25:0] tick_tot_r;
  always_ff @(posedge clk_i) begin
    if (!rstn_i) tick_tot_r <= '0;
    else tick_tot_r <= in_wfe ? tick_tot_r + {25'h0000000, tk.tick} : 26'h0000000;
  end
  wire [25:0] tmo_expect = 26'(frame_last + 17'h00001) * 26'(9'(par_r[P_TRIAL]) + 9'h001);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  a_idle_cmd_start: assert property ((state_r == S_IDLE) && byte_in && cmd_byte_i == CMD_IDLE && !cmd_last_i
    |=> state_r == S_LEN) else $error("idle command byte not taken");
  a_len_good_params: assert property ((state_r == S_LEN) && byte_in && cmd_byte_i == LEN_IDLE && !cmd_last_i
    |=> state_r == S_PAR) else $error("good length did not open parameters");
  a_cause_allowed: assert property ((state_r == S_RSP) && !err_r
    |-> cause_r != 8'h00 && (cause_r & ~par_r[P_SRC]) == 8'h00) else $error("wake cause not allowed");
  a_timeout_span: assert property (timeout |-> tick_tot_r + 26'h0000001 == tmo_expect)
    else $error("timeout at wrong slow period count");
  a_osc_settle_len: assert property ((state_r == S_OSC) && state_nxt == S_DAC
    |-> set_cnt_r == par_r[P_OSC]) else $error("oscillator settle length wrong");
  a_ok_reply_seq: assert property (rsp_enter && !err_nxt
    |=> rsp_valid_o && rsp_byte_o == RSP_OK && !rsp_last_o) else $error("ok reply head wrong");
  a_ok_reply_len: assert property (rsp_step && !err_r && rsp_idx_r == 2'h0
    |=> rsp_byte_o == RSP_OK_LEN && !rsp_last_o) else $error("ok reply length byte wrong");
  a_err_reply_seq: assert property (rsp_enter && err_nxt
    |=> rsp_valid_o && rsp_byte_o == RSP_ERR && !rsp_last_o) else $error("error reply head wrong");
  a_err_no_wait: assert property ((state_r == S_RSP) && err_r |-> !wait_mode_o && !fast_osc_settle_o)
    else $error("wait mode after bad length");
  a_burst_tag_only: assert property (detect_burst_o |-> par_r[P_SRC][SRC_TAG] && $past(frame_end))
    else $error("burst without tag source");

  c_ok_reply:   cover property (rsp_done && !err_r);
  c_err_reply:  cover property (rsp_done && err_r);
  c_timer_wake: cover property (in_wfe && wake_vec[SRC_TIMER]);
  c_pin_wake:   cover property (in_wfe && wake_vec[3]);
endmodule // iwc_idle_unit

// *** iwc_pkg.sv ***
// Constants, defaults and state encoding for the idle wake-up command unit.
// Assumes one 250 MHz clock shared by every module of the unit.
package iwc_pkg;
  localparam int unsigned CLK_HZ       = 250_000_000;
  localparam int unsigned SLOW_HZ_32K  = 32_000;
  localparam int unsigned SLOW_HZ_16K  = 16_000;
  localparam int unsigned SLOW_HZ_8K   = 8_000;
  localparam int unsigned SLOW_HZ_4K   = 4_000;
  localparam int unsigned SLOW_CYC_32K = (CLK_HZ + SLOW_HZ_32K - 1) / SLOW_HZ_32K;
  localparam int unsigned SLOW_CYC_16K = (CLK_HZ + SLOW_HZ_16K - 1) / SLOW_HZ_16K;
  localparam int unsigned SLOW_CYC_8K  = (CLK_HZ + SLOW_HZ_8K - 1) / SLOW_HZ_8K;
  localparam int unsigned SLOW_CYC_4K  = (CLK_HZ + SLOW_HZ_4K - 1) / SLOW_HZ_4K;
  localparam int unsigned TICK_W       = 16;

  localparam logic [7:0] CMD_IDLE    = 8'h07;
  localparam logic [7:0] LEN_IDLE    = 8'h0E;
  localparam logic [7:0] RSP_OK      = 8'h00;
  localparam logic [7:0] RSP_OK_LEN  = 8'h01;
  localparam logic [7:0] RSP_ERR     = 8'h82;
  localparam logic [7:0] RSP_ERR_LEN = 8'h00;
  localparam logic [7:0] SRC_MASK    = 8'h1B;
  localparam logic [1:0] RSP_OK_LAST  = 2'h2;
  localparam logic [1:0] RSP_ERR_LAST = 2'h1;

  localparam int unsigned NPAR    = 14;
  localparam int unsigned P_SRC   = 0;
  localparam int unsigned P_ENT_L = 1;
  localparam int unsigned P_ENT_H = 2;
  localparam int unsigned P_WAK_L = 3;
  localparam int unsigned P_WAK_H = 4;
  localparam int unsigned P_LEV_L = 5;
  localparam int unsigned P_LEV_H = 6;
  localparam int unsigned P_PER   = 7;
  localparam int unsigned P_OSC   = 8;
  localparam int unsigned P_DAC   = 9;
  localparam int unsigned P_CMP_L = 10;
  localparam int unsigned P_CMP_H = 11;
  localparam int unsigned P_SWING = 12;
  localparam int unsigned P_TRIAL = 13;
  localparam int unsigned SRC_TIMER = 0;
  localparam int unsigned SRC_TAG   = 1;
  localparam int unsigned RATE_LSB  = 6;

  localparam logic [7:0] RST_PAR [NPAR] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h18, 8'h00,
                                            8'h20, 8'h60, 8'h60, 8'h00, 8'h00, 8'h3F, 8'h01};

  typedef enum logic [7:0] {
    S_IDLE  = 8'h01,
    S_LEN   = 8'h02,
    S_PAR   = 8'h04,
    S_DRAIN = 8'h08,
    S_WFE   = 8'h10,
    S_OSC   = 8'h20,
    S_DAC   = 8'h40,
    S_RSP   = 8'h80
  } iwc_state_e;
endpackage

// *** iwc_tick_if.sv ***
// Carrier between the command unit and its slow-tick generator.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface iwc_tick_if;
  logic       run;
  logic [1:0] rate;
  logic       tick;
  modport ctl (output run, output rate, input tick);
  modport gen (input run, input rate, output tick);
endinterface

// *** iwc_slow_tick.sv ***
// Slow oscillator period generator: one tick pulse per slow period while run is high.
// Assumes rate is stable while run is high.
`timescale 1ns/1ps
module iwc_slow_tick
  import iwc_pkg::*;
#(
  parameter int unsigned CYC_32K = SLOW_CYC_32K,
  parameter int unsigned CYC_16K = SLOW_CYC_16K,
  parameter int unsigned CYC_8K  = SLOW_CYC_8K,
  parameter int unsigned CYC_4K  = SLOW_CYC_4K
) (
  input  wire logic clk_i,
  input  wire logic rstn_i,
  iwc_tick_if.gen   tk
);
  logic [TICK_W-1:0] cnt_r;
  logic [TICK_W-1:0] cnt_nxt;
  logic [TICK_W-1:0] limit;
  logic              wrap;
  logic              tick_r;

  assign limit   = (tk.rate == 2'h0) ? TICK_W'(CYC_32K - 1) :
                   (tk.rate == 2'h1) ? TICK_W'(CYC_16K - 1) :
                   (tk.rate == 2'h2) ? TICK_W'(CYC_8K - 1)  : TICK_W'(CYC_4K - 1);
  assign wrap    = tk.run && (cnt_r == limit);
  assign cnt_nxt = (!tk.run || wrap) ? '0 : cnt_r + 1'b1;
  assign tk.tick = tick_r;

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cnt_r  <= '0;
      tick_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      tick_r <= wrap;
    end
  end

  a_tick_isolated: assert property (@(posedge clk_i) disable iff (!rstn_i)
    tk.tick |=> !tk.tick) else $error("slow tick lasted more than one cycle");
endmodule // iwc_slow_tick

// *** iwc_host_model.sv ***
// Host side model: sends idle request frames byte by byte and takes reply bytes.
// Assumes one shared clock; drives its outputs 1 ns after the rising edge.
`timescale 1ns/1ps
module iwc_host_model (
  input  wire logic       clk_i,
  input  wire logic       rsp_valid_i,
  input  wire logic [7:0] rsp_byte_i,
  input  wire logic       rsp_last_i,
  output logic            cmd_valid_o,
  output logic [7:0]      cmd_byte_o,
  output logic            cmd_last_o,
  output logic            rsp_ready_o
);
  initial begin
    cmd_valid_o = 1'b0;
    cmd_byte_o  = 8'h00;
    cmd_last_o  = 1'b0;
    rsp_ready_o = 1'b0;
  end

  // Sends 07, a length byte, then the first n parameters; last flag on the final byte
  task automatic send_frame(input logic [7:0] len, input logic [7:0] p [14], input int n);
    logic [7:0] b;
    for (int i = -2; i < n; i++) begin
      b = (i == -2) ? 8'h07 : (i == -1) ? len : p[i];
      cmd_valid_o = 1'b1;
      cmd_byte_o  = b;
      cmd_last_o  = (i == n - 1);
      @(posedge clk_i);
      #1;
    end
    cmd_valid_o = 1'b0;
    cmd_last_o  = 1'b0;
    // Released data lines never keep the last byte
    cmd_byte_o  = ~b;
  endtask

  // Waits for a reply byte, stalls, then holds ready until the accepting edge
  task automatic recv(input int stall, output logic [7:0] b, output logic lst);
    int k;
    k = 0;
    while (rsp_valid_i !== 1'b1 && k < 20000) begin
      @(posedge clk_i);
      #1;
      k++;
    end
    // At least one edge with ready low between two accepted bytes
    repeat (stall + 1) begin
      @(posedge clk_i);
      #1;
    end
    rsp_ready_o = 1'b1;
    @(posedge clk_i);
    b   = rsp_byte_i;
    lst = rsp_last_i;
    #1;
    rsp_ready_o = 1'b0;
  endtask
endmodule // iwc_host_model

// *** tb_idle_wakeup_command_unit.sv ***
// Self-checking bench for the idle wake-up command unit.
// Assumes shortened slow periods of 4/5/6/7 clocks so timeouts stay short.
`timescale 1ns/1ps
module tb_idle_wakeup_command_unit;
  import iwc_pkg::*;
  logic       clk_i;
  logic       rstn_i;
  logic       cmd_valid, cmd_last, rsp_ready, rsp_valid, rsp_last;
  logic [7:0] cmd_byte, rsp_byte;
  logic       irq_pin, ss_pin, tag_det;
  logic       wait_mode, burst, osc_settle, conv_settle;
  logic [7:0] ent_l, ent_h, wak_l, wak_h, lev_l, lev_h, cmp_l, cmp_h, swing;
  int         errors, samples_checked, cycles;
  logic [7:0] p [14];
  logic [7:0] srcs [3];
  int         nw, nb, no, nd;

  iwc_idle_unit #(.CYC_32K(4), .CYC_16K(5), .CYC_8K(6), .CYC_4K(7)) u_dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .cmd_valid_i(cmd_valid), .cmd_byte_i(cmd_byte),
    .cmd_last_i(cmd_last), .rsp_ready_i(rsp_ready), .rsp_valid_o(rsp_valid), .rsp_byte_o(rsp_byte),
    .rsp_last_o(rsp_last), .irq_in_pin_i(irq_pin), .slave_sel_pin_i(ss_pin), .tag_detect_i(tag_det),
    .wait_mode_o(wait_mode), .detect_burst_o(burst), .fast_osc_settle_o(osc_settle),
    .converter_settle_o(conv_settle), .entry_control_low_o(ent_l), .entry_control_high_o(ent_h),
    .wake_control_low_o(wak_l), .wake_control_high_o(wak_h), .leave_control_low_o(lev_l),
    .leave_control_high_o(lev_h), .cmp_low_o(cmp_l), .cmp_high_o(cmp_h), .swing_count_o(swing));

  iwc_host_model u_host (
    .clk_i(clk_i), .rsp_valid_i(rsp_valid), .rsp_byte_i(rsp_byte), .rsp_last_i(rsp_last),
    .cmd_valid_o(cmd_valid), .cmd_byte_o(cmd_byte), .cmd_last_o(cmd_last), .rsp_ready_o(rsp_ready));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic final_report();
    if (errors == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Hang guard well above the longest timeout run
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      final_report();
    end
  end

  task automatic chk8(input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  task automatic chk_rng(input int lo, input int hi, input int got);
    samples_checked++;
    if (got < lo || got > hi) begin
      errors++;
      $display("MISMATCH t=%0t exp=%h..%h got=%h", $time, lo, hi, got);
    end
  endtask

  // Three reply bytes: result, length, cause with last flag
  task automatic expect_reply(input logic [7:0] cause, input int stall);
    logic [7:0] b;
    logic       l;
    u_host.recv(stall, b, l);
    chk8(RSP_OK, b);
    u_host.recv(0, b, l);
    chk8(RSP_OK_LEN, b);
    u_host.recv(stall, b, l);
    chk8(cause, b);
    chk8(8'h01, {7'h00, l});
  endtask

  // Counts wait, settle and first burst cycles until a reply shows
  task automatic run_to_reply();
    int k;
    nw = 0; nb = 0; no = 0; nd = 0; k = 0;
    while (rsp_valid !== 1'b1 && k < 20000) begin
      nw += (wait_mode === 1'b1);
      no += (osc_settle === 1'b1);
      nd += (conv_settle === 1'b1);
      if (burst === 1'b1 && nb == 0) nb = nw;
      @(posedge clk_i);
      #1;
      k++;
    end
  endtask

  initial begin
    logic [7:0] b;
    logic       l;
    errors = 0; samples_checked = 0; cycles = 0;
    rstn_i = 1'b0; irq_pin = 1'b1; ss_pin = 1'b1; tag_det = 1'b0;
    repeat (12) @(posedge clk_i);
    #1;
    rstn_i = 1'b1;
    chk8(8'h18, lev_l);
    chk8(8'h00, lev_h);
    chk8(8'h3F, swing);
    chk8(8'h00, {7'h00, wait_mode});

    // Bad length and cut-short frames: error reply, no wait mode
    p = '{8'h08, 8'h01, 8'h00, 8'h38, 8'h00, 8'h18, 8'h00, 8'h00, 8'h02, 8'h03, 8'h00, 8'h74, 8'h2A, 8'h01};
    for (int i = 0; i < 2; i++) begin
      u_host.send_frame((i == 0) ? 8'h0D : LEN_IDLE, p, (i == 0) ? 13 : 0);
      u_host.recv(2, b, l);
      chk8(RSP_ERR, b);
      chk8(8'h00, {7'h00, wait_mode});
      u_host.recv(0, b, l);
      chk8(RSP_ERR_LEN, b);
      chk8(8'h01, {7'h00, l});
    end

    // Pin and tag wakes, each with a settle wait of 2 then 3 slow periods
    srcs = '{8'h08, 8'h10, 8'h02};
    for (int i = 0; i < 3; i++) begin
      p[0] = srcs[i];
      p[1] = 8'h21 + 8'(i);
      u_host.send_frame(LEN_IDLE, p, 14);
      repeat (20) @(posedge clk_i);
      #1;
      chk8(8'h01, {7'h00, wait_mode});
      chk8(8'h00, {7'h00, rsp_valid});
      chk8(8'h21 + 8'(i), ent_l);
      chk8(8'h00, ent_h);
      chk8(8'h38, wak_l);
      chk8(8'h00, wak_h);
      chk8(8'h18, lev_l);
      chk8(8'h00, cmp_l);
      chk8(8'h74, cmp_h);
      chk8(8'h2A, swing);
      if (i == 0) irq_pin = 1'b0;
      if (i == 1) ss_pin = 1'b0;
      if (i == 2) tag_det = 1'b1;
      repeat ((i == 2) ? 1 : 6) @(posedge clk_i);
      #1;
      irq_pin = 1'b1; ss_pin = 1'b1; tag_det = 1'b0;
      run_to_reply();
      chk_rng(4, 9, no);
      chk_rng(11, 13, nd);
      expect_reply(srcs[i], i);
    end

    // Timeout: timer and tag allowed, period 00, trial 01, 32 kHz code
    p = '{8'h03, 8'h21, 8'h00, 8'h38, 8'h00, 8'h18, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40, 8'h3F, 8'h01};
    u_host.send_frame(LEN_IDLE, p, 14);
    run_to_reply();
    chk_rng(4090, 4104, nw);
    chk_rng(2040, 2056, nb);
    chk_rng(0, 0, no + nd);
    expect_reply(8'h01, 1);

    // Slowest rate code stretches every slow period to 7 clocks
    p[0] = 8'hC1;
    p[13] = 8'h01;
    u_host.send_frame(LEN_IDLE, p, 14);
    run_to_reply();
    chk_rng(7160, 7180, nw);
    expect_reply(8'h01, 0);
    final_report();
  end
endmodule // tb_idle_wakeup_command_unit
